// *** dadd_core.sv ***
`timescale 1ns/1ps
module dadd_core (
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic [7:0] ADR_I,
	input wire logic [31:0] DAT_I,
	output logic [31:0] DAT_O,
	input wire logic WE_I,
	input wire logic [3:0] SEL_I,
	input wire logic CYC_I,
	input wire logic STB_I,
	output logic ACK_I_O,
	input wire logic DRIVE_INPUT,
	input wire logic PWM_START,
	input wire logic SETPOINT_REACHED,
	input wire logic [31:0] FB_SAMPLE,
	input wire logic FB_SAMPLE_VALID,
	output logic [15:0] EFFECTIVE_SETPOINT,
	output logic CLAMP_ACTIVE,
	output logic OUTPUT_ON
);
	// ========================================
	// registers
	logic [31:0] step_reg, ctrl_reg, clkdiv_reg, ontime_reg;
	logic [1:0] mode_reg;
	logic [14:0] setpoint;
	logic channel_enable;
	logic [31:0] fb_hold;
	logic pending;
	logic [4:0] act_steps, act_flat;
	logic [11:0] act_size;
	logic act_deep;
	logic [1:0] drv_sync;
	logic [1:0] pwm_sync;
	logic [1:0] spr_sync;
	logic acc;
	logic en_d;
	localparam int DADD_DIVIDER_MANTISSA_W = dadd_pkg::DADD_DIVIDER_MANTISSA_W;
	localparam int DADD_EXP_LSB = dadd_pkg::DADD_EXP_LSB;
	localparam int DADD_SIZE_LSB_L = dadd_pkg::DADD_SIZE_LSB;
	logic period_start;
	wire logic wr = CYC_I && STB_I && WE_I && !ACK_I_O;
	wire logic [7:0] divider_mantissa = clkdiv_reg[DADD_DIVIDER_MANTISSA_W-1:0];
	wire logic [3:0] divider_exponent = clkdiv_reg[DADD_EXP_LSB +: 4];
	wire logic is_icc = mode_reg == dadd_pkg::DADD_MODE_ICC;
	wire logic pwm_lock = clkdiv_reg[dadd_pkg::DADD_PWMSYNC_BIT] && is_icc;
	wire logic sp_lock = clkdiv_reg[dadd_pkg::DADD_SPSYNC_BIT] && is_icc;
	// ========================================
	// wishbone slave
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B)
			ACK_I_O <= 1'b0;
		else
			ACK_I_O <= CYC_I && STB_I && !ACK_I_O;
	end
	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		hit = a == o;
	endfunction
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			step_reg <= 32'h00000000;
			ctrl_reg <= 32'h00000000;
			clkdiv_reg <= {20'h00000, dadd_pkg::DADD_EXP_RST, dadd_pkg::DADD_DIVIDER_MANTISSA_RST};
			ontime_reg <= 32'h00000000;
			mode_reg <= 2'h0;
			setpoint <= 15'h0000;
			channel_enable <= 1'b0;
		end else if (wr && SEL_I == 4'hF) begin
			if (hit(ADR_I, dadd_pkg::DADD_ADDR_STEP))
				step_reg <= DAT_I;
			if (hit(ADR_I, dadd_pkg::DADD_ADDR_CTRL))
				ctrl_reg <= DAT_I;
			if (hit(ADR_I, dadd_pkg::DADD_ADDR_CLKDIV))
				clkdiv_reg <= DAT_I;
			if (hit(ADR_I, dadd_pkg::DADD_ADDR_ONTIME))
				ontime_reg <= DAT_I;
			if (hit(ADR_I, dadd_pkg::DADD_ADDR_MODE))
				mode_reg <= DAT_I[1:0];
			if (hit(ADR_I, dadd_pkg::DADD_ADDR_SETPT)) begin
				setpoint <= DAT_I[14:0];
				channel_enable <= DAT_I[dadd_pkg::DADD_EN_BIT];
			end
		end
	end
	// ========================================
	// pin synchronisers
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			drv_sync <= 2'b00;
			pwm_sync <= 2'b00;
			spr_sync <= 2'b00;
		end else begin
			drv_sync <= {drv_sync[0], DRIVE_INPUT};
			pwm_sync <= {pwm_sync[0], PWM_START};
			spr_sync <= {spr_sync[0], SETPOINT_REACHED};
		end
	end
	logic pwm_d, spr_d;
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			pwm_d <= 1'b0;
			spr_d <= 1'b0;
			en_d <= 1'b0;
		end else begin
			pwm_d <= pwm_sync[1];
			spr_d <= spr_sync[1];
			en_d <= channel_enable;
		end
	end
	wire logic pwm_edge = pwm_sync[1] && !pwm_d;
	wire logic spr_edge = spr_sync[1] && !spr_d;
	wire logic en_rise = channel_enable && !en_d;
	// ========================================
	// reference clock divider: divider_mantissa << exp cycles
	logic [23:0] div_cnt;
	wire logic [23:0] div_len = 24'({16'h0000, divider_mantissa} << divider_exponent);
	wire logic tick = div_cnt + 24'h000001 >= div_len;
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B)
			div_cnt <= 24'h000000;
		else if (tick || period_start)
			div_cnt <= 24'h000000;
		else
			div_cnt <= div_cnt + 24'h000001;
	end
	// ========================================
	// pending update flag from control writes
	wire logic ctrl_wr = wr && SEL_I == 4'hF && hit(ADR_I, dadd_pkg::DADD_ADDR_CTRL);
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B)
			pending <= 1'b0;
		else if (ctrl_wr)
			pending <= 1'b1;
		else if (period_start)
			pending <= 1'b0;
	end
	// ========================================
	// dither generator
	dadd_pkg::dadd_phase_e phase;
	logic [7:0] tcnt;
	logic [16:0] overlay;
	// phase of step k: 2*steps up, flat, 2*steps down, flat
	function automatic dadd_pkg::dadd_phase_e step_ph(input logic [7:0] k,
		input logic [4:0] s, input logic [4:0] f);
		logic [7:0] up;
		logic [7:0] top;
		logic [7:0] dn;
		up = {2'b00, s, 1'b0};
		top = up + {3'b000, f};
		dn = top + up;
		if (k < up)
			step_ph = dadd_pkg::DADD_PH_RISE;
		else if (k < top)
			step_ph = dadd_pkg::DADD_PH_TOP;
		else if (k < dn)
			step_ph = dadd_pkg::DADD_PH_FALL;
		else
			step_ph = dadd_pkg::DADD_PH_BOT;
	endfunction
	wire logic [7:0] len_raw = {1'b0, act_steps, 2'b00}
		+ {2'b00, act_flat, 1'b0};
	wire logic [7:0] plen = (len_raw == 8'h00) ? 8'h01 : len_raw;
	wire logic done = tcnt >= plen;
	wire logic end_period = tick && done;
	wire logic sync_req = (pwm_lock && pwm_edge) || (sp_lock && spr_edge);
	wire logic want_lock = pwm_lock || sp_lock;
	assign period_start = en_rise || (want_lock ? (done && sync_req)
		: end_period);
	wire logic upd = period_start && (pending || en_rise);
	wire logic [4:0] use_steps = upd ? step_reg[4:0] : act_steps;
	wire logic [11:0] use_size = upd ? step_reg[DADD_SIZE_LSB_L +: 12]
		: act_size;
	wire logic [4:0] use_flat = upd ? ctrl_reg[4:0] : act_flat;
	dadd_pkg::dadd_phase_e first_ph;
	dadd_pkg::dadd_phase_e cur_ph;
	assign first_ph = step_ph(8'h00, use_steps, use_flat);
	assign cur_ph = step_ph(tcnt, act_steps, act_flat);
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			act_steps <= 5'h00;
			act_flat <= 5'h00;
			act_size <= 12'h000;
			act_deep <= 1'b0;
		end else if (upd) begin
			act_steps <= use_steps;
			act_size <= use_size;
			act_flat <= use_flat;
			act_deep <= ctrl_reg[dadd_pkg::DADD_DEEP_BIT];
		end
	end
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			phase <= dadd_pkg::DADD_PH_BOT;
			tcnt <= 8'h00;
			overlay <= 17'h00000;
		end else if (period_start) begin
			phase <= first_ph;
			tcnt <= 8'h01;
			if (first_ph == dadd_pkg::DADD_PH_RISE)
				overlay <= {5'h00, use_size};
			else
				overlay <= 17'h00000;
		end else if (tick && !done) begin
			phase <= cur_ph;
			tcnt <= tcnt + 8'h01;
			case (cur_ph)
			dadd_pkg::DADD_PH_RISE:
				overlay <= overlay + {5'h00, act_size};
			dadd_pkg::DADD_PH_FALL:
				overlay <= overlay - {5'h00, act_size};
			default:
				overlay <= overlay;
			endcase
		end
	end
	// ========================================
	// effective setpoint: overlay around average
	wire logic [16:0] amp = 17'(act_steps * act_size);
	wire logic [16:0] sum = {2'b00, setpoint} + overlay - amp;
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B)
			EFFECTIVE_SETPOINT <= 16'h0000;
		else if (setpoint == 15'h0000)
			EFFECTIVE_SETPOINT <= 16'h0000;
		else
			EFFECTIVE_SETPOINT <= sum[15:0];
	end
	// ========================================
	// autolimit clamp
	logic [1:0] clamp_cnt;
	logic [14:0] sp_d;
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			clamp_cnt <= 2'h0;
			sp_d <= 15'h0000;
		end else begin
			sp_d <= setpoint;
			if (sp_d != setpoint)
				clamp_cnt <= dadd_pkg::DADD_AUTOLIM_CYC;
			else if (pwm_edge && clamp_cnt != 2'h0)
				clamp_cnt <= clamp_cnt - 2'h1;
		end
	end
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B)
			CLAMP_ACTIVE <= 1'b0;
		else
			CLAMP_ACTIVE <= clamp_cnt != 2'h0 || (act_deep && is_icc);
	end
	// ========================================
	// direct drive
	logic [23:0] dd_cnt;
	wire logic [23:0] ton_len = 24'({16'h0000, ontime_reg[7:0]} << divider_exponent);
	wire logic active = channel_enable && setpoint != 15'h0000;
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B)
			dd_cnt <= 24'h000000;
		else if (dd_cnt + 24'h000001 >= div_len)
			dd_cnt <= 24'h000000;
		else
			dd_cnt <= dd_cnt + 24'h000001;
	end
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B)
			OUTPUT_ON <= 1'b0;
		else if (!active)
			OUTPUT_ON <= 1'b0;
		else if (mode_reg == dadd_pkg::DADD_MODE_PIN)
			OUTPUT_ON <= drv_sync[1];
		else if (mode_reg == dadd_pkg::DADD_MODE_TIMED)
			OUTPUT_ON <= dd_cnt < ton_len;
		else
			OUTPUT_ON <= 1'b0;
	end
	// ========================================
	// averaged feedback hold
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B)
			fb_hold <= 32'h00000000;
		else if (FB_SAMPLE_VALID && !(sp_lock && !active))
			fb_hold <= FB_SAMPLE;
	end
	// ========================================
	// read mux
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B)
			DAT_O <= 32'h00000000;
		else if (CYC_I && STB_I && !WE_I) begin
			case (ADR_I)
			dadd_pkg::DADD_ADDR_STEP: DAT_O <= step_reg;
			dadd_pkg::DADD_ADDR_CTRL: DAT_O <= ctrl_reg;
			dadd_pkg::DADD_ADDR_CLKDIV: DAT_O <= clkdiv_reg;
			dadd_pkg::DADD_ADDR_MODE: DAT_O <= {30'h00000000, mode_reg};
			dadd_pkg::DADD_ADDR_SETPT: DAT_O <= {16'h0000, channel_enable, setpoint};
			dadd_pkg::DADD_ADDR_ONTIME: DAT_O <= ontime_reg;
			dadd_pkg::DADD_ADDR_STATUS: DAT_O <= {12'h000, pending, CLAMP_ACTIVE,
				phase, overlay[15:0]};
			dadd_pkg::DADD_ADDR_FB: DAT_O <= fb_hold;
			default: DAT_O <= dadd_pkg::DADD_BAD_DATA;
			endcase
		end
	end
	// ========================================
	// assertions
	a_zero_setpoint: assert property (@(posedge CLK) disable iff (!RST_B)
		setpoint == 15'h0000 |=> EFFECTIVE_SETPOINT == 16'h0000)
		else $error("overlay present with zero setpoint");
	a_pin_follow: assert property (@(posedge CLK) disable iff (!RST_B)
		(active && mode_reg == dadd_pkg::DADD_MODE_PIN) |=> OUTPUT_ON == $past(drv_sync[1]))
		else $error("output not following drive pin");
	a_deep_clamp: assert property (@(posedge CLK) disable iff (!RST_B)
		(act_deep && is_icc) |=> CLAMP_ACTIVE)
		else $error("deep dither clamp inactive");
	a_enable_restart: assert property (@(posedge CLK) disable iff (!RST_B)
		en_rise |=> tcnt == 8'h01
		&& (overlay == {5'h00, act_size} || overlay == 17'h00000))
		else $error("enable did not restart dither");
	a_period_bound: assert property (@(posedge CLK) disable iff (!RST_B)
		tcnt <= plen)
		else $error("dither step count beyond period");
	a_start_bottom: assert property (@(posedge CLK) disable iff (!RST_B)
		(period_start && !en_rise) |-> overlay == 17'h00000)
		else $error("period started away from bottom");
	a_ctrl_pending: assert property (@(posedge CLK) disable iff (!RST_B)
		ctrl_wr |=> pending)
		else $error("control write not pending");
	a_clamp_start: assert property (@(posedge CLK) disable iff (!RST_B)
		sp_d != setpoint |=> ##1 CLAMP_ACTIVE)
		else $error("clamp not started after setpoint change");
	a_fb_freeze: assert property (@(posedge CLK) disable iff (!RST_B)
		(sp_lock && !active) |=> $stable(fb_hold))
		else $error("feedback changed while frozen");
	a_off_inactive: assert property (@(posedge CLK) disable iff (!RST_B)
		!active |=> !OUTPUT_ON)
		else $error("output on while inactive");
endmodule

// *** dadd_pkg.sv ***
package dadd_pkg;
	// ========================================
	// register map (word offsets as byte addresses)
	localparam logic [7:0] DADD_ADDR_STEP = 8'h00;
	localparam logic [7:0] DADD_ADDR_CTRL = 8'h04;
	localparam logic [7:0] DADD_ADDR_CLKDIV = 8'h08;
	localparam logic [7:0] DADD_ADDR_MODE = 8'h0C;
	localparam logic [7:0] DADD_ADDR_SETPT = 8'h10;
	localparam logic [7:0] DADD_ADDR_ONTIME = 8'h14;
	localparam logic [7:0] DADD_ADDR_STATUS = 8'h18;
	localparam logic [7:0] DADD_ADDR_FB = 8'h1C;
	// ========================================
	// field widths and positions
	localparam int DADD_STEPS_W = 5;
	localparam int DADD_SIZE_W = 12;
	localparam int DADD_FLAT_W = 5;
	localparam int DADD_DIVIDER_MANTISSA_W = 8;
	localparam int DADD_EXP_W = 4;
	localparam int DADD_SET_W = 15;
	localparam int DADD_SIZE_LSB = 8;
	localparam int DADD_DEEP_BIT = 5;
	localparam int DADD_EXP_LSB = 8;
	localparam int DADD_PWMSYNC_BIT = 12;
	localparam int DADD_SPSYNC_BIT = 13;
	localparam int DADD_EN_BIT = 15;
	// ========================================
	// reset values and unmapped read data
	localparam logic [7:0] DADD_DIVIDER_MANTISSA_RST = 8'h01;
	localparam logic [3:0] DADD_EXP_RST = 4'h0;
	localparam logic [31:0] DADD_BAD_DATA = 32'h00000000;
	// ========================================
	// autolimit window in pwm cycles
	localparam logic [1:0] DADD_AUTOLIM_CYC = 2'h2;
	// ========================================
	// channel modes
	typedef enum logic [1:0] {
		DADD_MODE_ICC = 2'b00,
		DADD_MODE_PIN = 2'b01,
		DADD_MODE_TIMED = 2'b10,
		DADD_MODE_OFF = 2'b11
	} dadd_mode_e;
	// dither phases
	typedef enum logic [1:0] {
		DADD_PH_RISE = 2'b00,
		DADD_PH_TOP = 2'b01,
		DADD_PH_FALL = 2'b10,
		DADD_PH_BOT = 2'b11
	} dadd_phase_e;
endpackage

// *** dadd_host_model.sv ***
`timescale 1ns/1ps
// ========================================
// controller side: drive pin, pwm starts, setpoint reached
module dadd_host_model (
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic drv_level,
	input wire logic reach_req,
	output logic DRIVE_INPUT,
	output logic PWM_START,
	output logic SETPOINT_REACHED
);
	logic [2:0] pwm_cnt;
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			DRIVE_INPUT <= 1'b0;
			SETPOINT_REACHED <= 1'b0;
		end else begin
			DRIVE_INPUT <= drv_level;
			SETPOINT_REACHED <= reach_req;
		end
	end
	// turn-on pulse every eight cycles
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			pwm_cnt <= 3'h0;
			PWM_START <= 1'b0;
		end else begin
			pwm_cnt <= pwm_cnt + 3'h1;
			PWM_START <= (pwm_cnt == 3'h7);
		end
	end
endmodule

// *** dither_and_direct_drive_test.sv ***
`timescale 1ns/1ps
module dither_and_direct_drive_test;
	logic clk, rst_b, we, cyc, stb, ack, drv, reach, pwm, hit, out_on;
	logic clamp;
	logic [31:0] rnd;
	logic [7:0] adr;
	logic [31:0] wdat, rdat, dat_o, seed;
	logic [15:0] eff;
	int n_fail, n_tests, cycles;
	// ========================================
	// design and controller model
	dadd_core i_dut (.CLK(clk), .RST_B(rst_b), .ADR_I(adr), .DAT_I(wdat),
		.DAT_O(dat_o), .WE_I(we), .SEL_I(4'hF), .CYC_I(cyc), .STB_I(stb),
		.ACK_I_O(ack), .DRIVE_INPUT(drv), .PWM_START(pwm),
		.SETPOINT_REACHED(hit), .FB_SAMPLE(seed), .FB_SAMPLE_VALID(cyc),
		.EFFECTIVE_SETPOINT(eff), .CLAMP_ACTIVE(clamp), .OUTPUT_ON(out_on));
	dadd_host_model i_host (.CLK(clk), .RST_B(rst_b), .drv_level(rdat[0]),
		.reach_req(reach), .DRIVE_INPUT(drv), .PWM_START(pwm),
		.SETPOINT_REACHED(hit));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			end_of_test();
		end
	end
	// ========================================
	// helpers
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (ack !== 1'b1 && k < 50);
		chk({31'h0, ack}, 32'h1);
		if (!w) rdat = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask
	task automatic end_of_test();
		$display("counts: %0d checks, %0d mismatches", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// ========================================
	// dither: step 2, size 16, flat 1, tick 2 clocks, period 20
	task automatic dither_run(input logic [15:0] sp);
		logic [15:0] q[$];
		logic [15:0] lo, hi, d;
		int last, rises;
		wb(1'b1, dadd_pkg::DADD_ADDR_CLKDIV, 32'h2);
		wb(1'b1, dadd_pkg::DADD_ADDR_STEP, 32'h1002);
		wb(1'b1, dadd_pkg::DADD_ADDR_CTRL, 32'h1);
		wb(1'b1, dadd_pkg::DADD_ADDR_SETPT, {16'h0, 1'b1, sp[14:0]});
		repeat (40) @(posedge clk);
		repeat (61) begin
			@(posedge clk);
			q.push_back(eff);
		end
		lo = q[0];
		hi = q[0];
		last = -1;
		rises = 0;
		for (int i = 1; i < 61; i++) begin
			if (q[i] !== q[i-1]) begin
				d = (q[i] > q[i-1]) ? q[i] - q[i-1] : q[i-1] - q[i];
				chk({16'h0, d}, 32'h10);
				if (q[i-1] === sp - 16'h20) begin
					if (last >= 0) chk(i - last, 20);
					last = i;
					rises++;
				end
			end
			if (q[i] < lo) lo = q[i];
			if (q[i] > hi) hi = q[i];
		end
		chk(rises, 3);
		chk({16'h0, hi - lo}, 32'h40);
		chk({16'h0, lo}, {16'h0, sp - 16'h20});
		$display("dither test done");
	endtask
	// ========================================
	// main sequence
	initial begin
		seed = 32'hD;
		rst_b = 1'b0;
		{we, cyc, stb, reach, adr, wdat, rdat} = '0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		wb(1'b0, dadd_pkg::DADD_ADDR_CLKDIV, 32'h0);
		chk(rdat, {20'h0, dadd_pkg::DADD_EXP_RST, dadd_pkg::DADD_DIVIDER_MANTISSA_RST});
		wb(1'b0, 8'h40, 32'h0);
		chk(rdat, dadd_pkg::DADD_BAD_DATA);
		$display("register test done");
		rnd = xs();
		dither_run({6'h0, rnd[9:0]} + 16'h100);
		reach <= 1'b1;
		wb(1'b1, dadd_pkg::DADD_ADDR_SETPT, 32'h8000);
		@(posedge clk);
		chk({31'h0, clamp}, 32'h1);
		repeat (40) @(posedge clk);
		chk({31'h0, clamp}, 32'h0);
		repeat (20) begin
			@(posedge clk);
			chk({16'h0, eff}, 32'h0);
		end
		$display("zero setpoint test done");
		wb(1'b1, dadd_pkg::DADD_ADDR_MODE, 32'h1);
		wb(1'b1, dadd_pkg::DADD_ADDR_SETPT, 32'h8100);
		repeat (8) begin
			rdat <= xs();
			repeat (6) @(posedge clk);
			chk({31'h0, out_on}, {31'h0, rdat[0]});
		end
		$display("pin drive test done");
		wb(1'b1, dadd_pkg::DADD_ADDR_CLKDIV, 32'h108);
		wb(1'b1, dadd_pkg::DADD_ADDR_ONTIME, 32'h3);
		wb(1'b1, dadd_pkg::DADD_ADDR_MODE, 32'h2);
		repeat (32) @(posedge clk);
		cycles = 0;
		n_tests++;
		wdat = 32'h0;
		repeat (64) begin
			@(posedge clk);
			if (out_on === 1'b1) wdat++;
		end
		chk(wdat, 32'd24);
		$display("timed drive test done");
		end_of_test();
	end
endmodule
